// file: ddr_cmd_defs.vh
// Constants for the command decoder and power-state tracker
`ifndef DDR_CMD_DEFS_VH
`define DDR_CMD_DEFS_VH
// Command codes {rowStrobe, colStrobe, writeEn} with chip select low
`define CMD_MODESET   3'h0
`define CMD_REFRESH   3'h1
`define CMD_PRECHARGE 3'h2
`define CMD_ACTIVATE  3'h3
`define CMD_WRITE     3'h4
`define CMD_READ      3'h5
`define CMD_CALIB     3'h6
`define CMD_NOP       3'h7
// Address bit positions
`define ADDR_AP_BIT   10
`define ADDR_BC_BIT   12
// Burst mode field codes
`define BL_FIXED8     2'h0
`define BL_OTF        2'h1
`define BL_FIXED4     2'h2
`define BL_RESET      2'h0
// Burst lengths in command-clock edges (data beats / 2)
`define BURST8_EDGES  4'h4
`define BURST4_EDGES  4'h2
// Fixed busy times in command-clock edges
`define PRE_EDGES     8'h04
`define REF_EDGES     8'h20
`define CAL_EDGES     8'h40
`define MRS_EDGES     8'h04
`define EXIT_EDGES    8'h08
`define WR_AFTER_SR   10'h200
`endif

// file: sdram_cmd_power_state_decode.v
// Command decoder and clock-enable power-state tracker of a DDR3 device
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_defs.vh"
module sdram_cmd_power_state_decode #(
    parameter BANKS   = 8,
    parameter BA_W    = 3,
    parameter ADDR_W  = 13,
    parameter DM_W    = 2
) (
    // System
    input  wire              clk,
    input  wire              rst_b,
    // Command pins from the controller
    input  wire              cmdClk,
    input  wire              chipSel_b,
    input  wire              rowStrobe_b,
    input  wire              colStrobe_b,
    input  wire              writeEn_b,
    input  wire              clkEn,
    input  wire [BA_W-1:0]   bankAddr,
    input  wire [ADDR_W-1:0] addr,
    input  wire [DM_W-1:0]   dataMask,
    input  wire              odtIn,
    // Decoded status
    output reg  [7:0]        powerState_ff,
    output reg  [BANKS-1:0]  bankOpen_ff,
    output reg               idle_ff,
    output reg  [DM_W-1:0]   writeLaneEn_ff,
    output reg               writeStrobe_ff,
    output reg  [BA_W-1:0]   cmdBank_ff,
    output reg  [2:0]        modeRegSel_ff,
    output reg               modeRegWrite_ff,
    output reg               refreshPulse_ff,
    output reg               termActive_ff,
    output reg               writeAllowed_ff
);
    localparam ST_IDLE = 8'h01;
    localparam ST_ACT  = 8'h02;
    localparam ST_RD   = 8'h04;
    localparam ST_WR   = 8'h08;
    localparam ST_PRE  = 8'h10;
    localparam ST_REF  = 8'h20;
    localparam ST_PD   = 8'h40;
    localparam ST_SR   = 8'h80;

    // Two-flop synchronisers for every pin
    localparam SW = 6 + BA_W + ADDR_W + DM_W;
    reg  [SW-1:0] sync1_ff;
    reg  [SW-1:0] sync2_ff;
    wire [SW-1:0] pins = {cmdClk, chipSel_b, rowStrobe_b, colStrobe_b, writeEn_b,
                          odtIn, bankAddr, addr, dataMask};
    reg           clkEnS1_ff;
    reg           clkEnS2_ff;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_ff   <= {SW{1'b1}};
            sync2_ff   <= {SW{1'b1}};
            clkEnS1_ff <= 1'b0;
            clkEnS2_ff <= 1'b0;
        end else begin
            sync1_ff   <= pins;
            sync2_ff   <= sync1_ff;
            clkEnS1_ff <= clkEn;
            clkEnS2_ff <= clkEnS1_ff;
        end
    end
    wire              sClk  = sync2_ff[SW-1];
    wire              sCs   = sync2_ff[SW-2];
    wire [2:0]        sCmd  = sync2_ff[SW-3:SW-5];
    wire              sOdt  = sync2_ff[SW-6];
    wire [BA_W-1:0]   sBa   = sync2_ff[BA_W+ADDR_W+DM_W-1:ADDR_W+DM_W];
    wire [ADDR_W-1:0] sAddr = sync2_ff[ADDR_W+DM_W-1:DM_W];
    wire [DM_W-1:0]   sDm   = sync2_ff[DM_W-1:0];

    reg cmdClkPrev_ff;
    reg clkEnPrev_ff;
    wire edgeN = sClk & ~cmdClkPrev_ff;

    // Command code, deselect folds into no-operation
    function [2:0] decodeCmd;
        input       cs;
        input [2:0] c;
        decodeCmd = cs ? `CMD_NOP : c;
    endfunction
    wire [2:0] cmd = decodeCmd(sCs, sCmd);

    reg  [1:0] blMode_ff;
    reg  [3:0] burstCnt_ff;
    reg  [7:0] busyCnt_ff;
    reg  [9:0] srExitCnt_ff;
    reg        autoPre_ff;
    reg  [BA_W-1:0] burstBank_ff;
    wire burstBusy = (burstCnt_ff != 4'h0);
    wire anyOpen   = |bankOpen_ff;
    wire [3:0] burstLen = (blMode_ff == `BL_FIXED4) ? `BURST4_EDGES :
                          (blMode_ff == `BL_OTF && !sAddr[`ADDR_BC_BIT]) ? `BURST4_EDGES :
                          `BURST8_EDGES;
    wire idleNow = !anyOpen && !burstBusy && (busyCnt_ff == 8'h00) && clkEnPrev_ff;
    wire ceFall  = clkEnPrev_ff & ~clkEnS2_ff;
    wire ceRise  = ~clkEnPrev_ff & clkEnS2_ff;

    reg [7:0] nxt_state;
    always @* begin
        nxt_state = powerState_ff;
        case (powerState_ff)
            ST_PD:   if (ceRise) nxt_state = anyOpen ? ST_ACT : ST_IDLE;
            ST_SR:   nxt_state = ST_SR;                            // Exit handled in the clocked block, without a command edge
            ST_IDLE: if (ceFall)
                         nxt_state = (cmd == `CMD_REFRESH && idleNow) ? ST_SR :
                                     ST_PD;
                     else if (cmd == `CMD_ACTIVATE) nxt_state = ST_ACT;
                     else if (cmd == `CMD_REFRESH && idleNow) nxt_state = ST_REF;
            ST_REF, ST_PRE, ST_RD, ST_WR, ST_ACT:
                     if (ceFall) nxt_state = ST_PD;
                     else if (burstBusy) nxt_state = powerState_ff;
                     else if (cmd == `CMD_READ && anyOpen) nxt_state = ST_RD;
                     else if (cmd == `CMD_WRITE && anyOpen) nxt_state = ST_WR;
                     else if (cmd == `CMD_PRECHARGE) nxt_state = ST_PRE;
                     else if (busyCnt_ff != 8'h00) nxt_state = powerState_ff;
                     else nxt_state = anyOpen ? ST_ACT : ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmdClkPrev_ff   <= 1'b1;
            clkEnPrev_ff    <= 1'b0;
            powerState_ff   <= ST_PD;
            bankOpen_ff     <= {BANKS{1'b0}};
            idle_ff         <= 1'b0;
            writeLaneEn_ff  <= {DM_W{1'b0}};
            writeStrobe_ff  <= 1'b0;
            cmdBank_ff      <= {BA_W{1'b0}};
            modeRegSel_ff   <= 3'h0;
            modeRegWrite_ff <= 1'b0;
            refreshPulse_ff <= 1'b0;
            termActive_ff   <= 1'b0;
            writeAllowed_ff <= 1'b1;
            blMode_ff       <= `BL_RESET;
            burstCnt_ff     <= 4'h0;
            busyCnt_ff      <= 8'h00;
            srExitCnt_ff    <= 10'h000;
            autoPre_ff      <= 1'b0;
            burstBank_ff    <= {BA_W{1'b0}};
        end else begin
            cmdClkPrev_ff   <= sClk;
            modeRegWrite_ff <= 1'b0;
            refreshPulse_ff <= 1'b0;
            writeStrobe_ff  <= 1'b0;
            termActive_ff   <= sOdt && (powerState_ff != ST_SR);
            if (powerState_ff == ST_SR && clkEnS2_ff) begin
                // Exit taken on the clock-enable level, no command edge needed
                powerState_ff   <= ST_IDLE;
                clkEnPrev_ff    <= 1'b1;
                busyCnt_ff      <= `EXIT_EDGES;
                srExitCnt_ff    <= `WR_AFTER_SR;
                writeAllowed_ff <= 1'b0;
                idle_ff         <= 1'b0;
            end else if (edgeN) begin
                clkEnPrev_ff  <= clkEnS2_ff;
                powerState_ff <= nxt_state;
                idle_ff       <= idleNow && clkEnS2_ff && (cmd == `CMD_NOP);
                if (busyCnt_ff != 8'h00 && powerState_ff != ST_PD)
                    busyCnt_ff <= busyCnt_ff - 8'h01;
                if (srExitCnt_ff != 10'h000)
                    srExitCnt_ff <= srExitCnt_ff - 10'h001;
                writeAllowed_ff <= (srExitCnt_ff <= 10'h001);
                if (burstBusy) begin
                    burstCnt_ff <= burstCnt_ff - 4'h1;
                    if (burstCnt_ff == 4'h1 && autoPre_ff)
                        bankOpen_ff[burstBank_ff] <= 1'b0;
                end
                if (powerState_ff == ST_WR && burstBusy) begin
                    writeStrobe_ff <= 1'b1;
                    writeLaneEn_ff <= ~sDm;
                end
                // Commands ignored in power-down and on clock-enable edges
                if (clkEnPrev_ff && clkEnS2_ff && powerState_ff != ST_PD) begin
                    case (cmd)
                        `CMD_MODESET: if (idleNow) begin
                            modeRegSel_ff   <= sBa[2:0];
                            modeRegWrite_ff <= 1'b1;
                            if (sBa == {BA_W{1'b0}})
                                blMode_ff <= sAddr[1:0];
                            busyCnt_ff <= `MRS_EDGES;
                        end
                        `CMD_REFRESH: if (idleNow) begin
                            refreshPulse_ff <= 1'b1;
                            busyCnt_ff      <= `REF_EDGES;
                        end
                        `CMD_PRECHARGE: begin
                            if (sAddr[`ADDR_AP_BIT])
                                bankOpen_ff <= {BANKS{1'b0}};
                            else
                                bankOpen_ff[sBa] <= 1'b0;
                            busyCnt_ff <= `PRE_EDGES;
                        end
                        `CMD_ACTIVATE: begin
                            bankOpen_ff[sBa] <= 1'b1;
                            cmdBank_ff       <= sBa;
                        end
                        `CMD_READ, `CMD_WRITE: if (!burstBusy && bankOpen_ff[sBa]) begin
                            burstCnt_ff  <= burstLen;
                            autoPre_ff   <= sAddr[`ADDR_AP_BIT];
                            burstBank_ff <= sBa;
                            cmdBank_ff   <= sBa;
                        end
                        `CMD_CALIB: if (idleNow) busyCnt_ff <= `CAL_EDGES;
                        default: ;
                    endcase
                end
            end
        end
    end
    // Busy counter deliberately never runs in power-down
endmodule // sdram_cmd_power_state_decode
`default_nettype wire

// file: sdram_cmd_power_state_decode_props.sv
// Assertion checker for the command decoder status ports
`timescale 1ns/10ps
`default_nettype none
module sdram_cmd_power_state_decode_props #(
    parameter BANKS = 8
) (
    // System
    input wire logic             clk,
    input wire logic             rst_b,
    // Status
    input wire logic [7:0]       powerState_ff,
    input wire logic [BANKS-1:0] bankOpen_ff,
    input wire logic             idle_ff,
    input wire logic             writeStrobe_ff,
    input wire logic             modeRegWrite_ff,
    input wire logic             refreshPulse_ff,
    input wire logic             termActive_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_state_onehot: assert property ($onehot(powerState_ff))
        else $error("power state not one-hot");
    a_sr_from_idle: assert property ($rose(powerState_ff[7]) |-> bankOpen_ff == '0)
        else $error("self-refresh entered with open bank");
    a_sr_term_off: assert property (powerState_ff[7] && $past(powerState_ff[7]) |-> !termActive_ff)
        else $error("termination active in self-refresh");
    a_pd_no_refresh: assert property (powerState_ff[6] && $past(powerState_ff[6]) |-> !refreshPulse_ff)
        else $error("refresh during power-down");
    a_idle_closed: assert property (idle_ff |-> $past(bankOpen_ff) == '0)
        else $error("idle with open bank");
    a_mrs_pulse: assert property (modeRegWrite_ff |=> !modeRegWrite_ff)
        else $error("mode write pulse too long");
    a_ref_pulse: assert property (refreshPulse_ff |=> !refreshPulse_ff)
        else $error("refresh pulse too long");
    a_wr_strobe: assert property (writeStrobe_ff |=> !writeStrobe_ff && !powerState_ff[7])
        else $error("write strobe malformed");
    cover property (powerState_ff == 8'h80);
    cover property (writeStrobe_ff);
    cover property (modeRegWrite_ff);
endmodule // sdram_cmd_power_state_decode_props
bind sdram_cmd_power_state_decode sdram_cmd_power_state_decode_props #(.BANKS(BANKS)) props_inst (
    .clk(clk), .rst_b(rst_b), .powerState_ff(powerState_ff), .bankOpen_ff(bankOpen_ff),
    .idle_ff(idle_ff), .writeStrobe_ff(writeStrobe_ff), .modeRegWrite_ff(modeRegWrite_ff),
    .refreshPulse_ff(refreshPulse_ff), .termActive_ff(termActive_ff));
`default_nettype wire

// file: ddr_ctrl_model.sv
// Behavioural memory controller driving the command pins
`timescale 1ns/10ps
`default_nettype none
module ddr_ctrl_model (
    // Command pins
    output var logic        cmdClk,
    output var logic        chipSel_b,
    output var logic [2:0]  cmdLines,
    output var logic        clkEn,
    output var logic [2:0]  bankAddr,
    output var logic [12:0] addr,
    output var logic [1:0]  dataMask
);
    logic run = 1'b1;
    initial begin
        {cmdClk, chipSel_b, cmdLines, clkEn, bankAddr, addr, dataMask} = {1'b0, 4'hf, 19'h0};
        #40;
        forever #160 cmdClk = run ? ~cmdClk : cmdClk;
    end
    // One command edge, then deselect with clock enable held
    task issue(input logic [2:0] c, input logic ke, input logic [2:0] ba,
               input logic [12:0] a, input logic [1:0] dm);
        @(negedge cmdClk);
        {chipSel_b, cmdLines, clkEn, bankAddr, addr, dataMask} <= {1'b0, c, ke, ba, a, dm};
        @(negedge cmdClk);
        chipSel_b <= 1'b1;
        bankAddr <= ~ba; // Released bank and address lines do not keep their value
        addr <= ~a;
    endtask
    // Park or restart the command clock at its present level
    task hold_clock(input logic stop);
        run = !stop;
    endtask
    // Clock enable rises alone with deselect, as for a self-refresh wake
    task wake;
        clkEn <= 1'b1;
    endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// file: test_sdram_cmd_power_state_decode.sv
// Testbench for the command decoder and power-state tracker
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_defs.vh"
module test_sdram_cmd_power_state_decode;
    logic clk = 1'b0, rst_b = 1'b0, odtIn = 1'b0;
    logic cmdClk, chipSel_b, clkEn, writeStrobe_ff, idle_ff, modeRegWrite_ff;
    logic refreshPulse_ff, termActive_ff, writeAllowed_ff;
    logic [2:0] cmdLines, bankAddr, cmdBank_ff, modeRegSel_ff;
    logic [12:0] addr;
    logic [1:0] dataMask, writeLaneEn_ff;
    logic [7:0] powerState_ff, bankOpen_ff;
    int failures = 0, samples_checked = 0, wrCnt = 0, mrCnt = 0, rfCnt = 0;
    ddr_ctrl_model ddr_ctrl_model_inst (.cmdClk(cmdClk), .chipSel_b(chipSel_b),
        .cmdLines(cmdLines), .clkEn(clkEn), .bankAddr(bankAddr), .addr(addr), .dataMask(dataMask));
    sdram_cmd_power_state_decode sdram_cmd_power_state_decode_inst (.clk(clk), .rst_b(rst_b),
        .cmdClk(cmdClk), .chipSel_b(chipSel_b), .rowStrobe_b(cmdLines[2]), .colStrobe_b(cmdLines[1]),
        .writeEn_b(cmdLines[0]), .clkEn(clkEn), .bankAddr(bankAddr), .addr(addr),
        .dataMask(dataMask), .odtIn(odtIn), .powerState_ff(powerState_ff), .bankOpen_ff(bankOpen_ff),
        .idle_ff(idle_ff), .writeLaneEn_ff(writeLaneEn_ff), .writeStrobe_ff(writeStrobe_ff),
        .cmdBank_ff(cmdBank_ff), .modeRegSel_ff(modeRegSel_ff), .modeRegWrite_ff(modeRegWrite_ff),
        .refreshPulse_ff(refreshPulse_ff), .termActive_ff(termActive_ff),
        .writeAllowed_ff(writeAllowed_ff));
    initial forever #20 clk = ~clk;
    always @(negedge clk) begin
        wrCnt += (writeStrobe_ff === 1'b1);
        mrCnt += (modeRegWrite_ff === 1'b1);
        rfCnt += (refreshPulse_ff === 1'b1);
    end
    task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task cmd(input logic [2:0] c, input logic ke, input logic [2:0] ba, input logic [12:0] a,
             input logic [1:0] dm, input int edges);
        ddr_ctrl_model_inst.issue(c, ke, ba, a, dm);
        repeat (edges) @(posedge cmdClk);
        repeat (6) @(negedge clk);
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task t_start;
        chk("reset state", powerState_ff, 8'h40);
        chk("reset wr allow", {7'h0, writeAllowed_ff}, 8'h01);
        cmd(`CMD_NOP, 1'b1, 3'h0, 13'h0, 2'h0, 10);
        chk("idle state", powerState_ff, 8'h01);
        chk("idle flag", {7'h0, idle_ff}, 8'h01);
        $display("start test done");
    endtask
    task t_modes;
        cmd(`CMD_MODESET, 1'b1, 3'h2, 13'h0, 2'h0, 6);
        chk("mode sel", {5'h0, modeRegSel_ff}, 8'h02);
        cmd(`CMD_MODESET, 1'b1, 3'h0, 13'h0001, 2'h0, 6);
        chk("mode writes", mrCnt[7:0], 8'h02);
        cmd(`CMD_REFRESH, 1'b1, 3'h0, 13'h0, 2'h0, 34);
        cmd(`CMD_CALIB, 1'b1, 3'h0, 13'h0400, 2'h0, 66);
        chk("refresh pulses", rfCnt[7:0], 8'h01);
        $display("modes test done");
    endtask
    task t_write;
        cmd(`CMD_ACTIVATE, 1'b1, 3'h5, 13'h0, 2'h0, 2);
        chk("bank open", bankOpen_ff, 8'h20);
        ddr_ctrl_model_inst.issue(`CMD_WRITE, 1'b1, 3'h5, 13'h0, 2'h1);
        repeat (2) @(posedge cmdClk);
        repeat (5) @(negedge clk);
        chk("lane mask", {6'h0, writeLaneEn_ff}, 8'h02);
        cmd(`CMD_NOP, 1'b1, 3'h0, 13'h0, 2'h0, 4);
        chk("chop strobes", wrCnt[7:0], 8'h02);
        cmd(`CMD_WRITE, 1'b1, 3'h5, 13'h1000, 2'h0, 6);
        chk("bl8 strobes", wrCnt[7:0], 8'h06);
        cmd(`CMD_ACTIVATE, 1'b1, 3'h2, 13'h0, 2'h0, 2);
        chk("two banks", bankOpen_ff, 8'h24);
        cmd(`CMD_READ, 1'b1, 3'h5, 13'h1400, 2'h0, 6);
        chk("read bank", {5'h0, cmdBank_ff}, 8'h05);
        chk("auto precharge", bankOpen_ff, 8'h04);
        chk("no read strobes", wrCnt[7:0], 8'h06);
        $display("write test done");
    endtask
    task t_power;
        cmd(`CMD_NOP, 1'b0, 3'h0, 13'h0, 2'h0, 2);
        chk("active pd", powerState_ff, 8'h40);
        cmd(`CMD_REFRESH, 1'b0, 3'h1, 13'h1fff, 2'h3, 2);
        chk("pd held", powerState_ff, 8'h40);
        chk("pd no refresh", rfCnt[7:0], 8'h01);
        cmd(`CMD_NOP, 1'b1, 3'h0, 13'h0, 2'h0, 10);
        chk("pd exit", powerState_ff, 8'h02);
        cmd(`CMD_ACTIVATE, 1'b1, 3'h6, 13'h0, 2'h0, 2);
        cmd(`CMD_PRECHARGE, 1'b1, 3'h2, 13'h0, 2'h0, 6);
        chk("one closed", bankOpen_ff, 8'h40);
        cmd(`CMD_PRECHARGE, 1'b1, 3'h0, 13'h0400, 2'h0, 6);
        chk("all closed", bankOpen_ff, 8'h00);
        $display("power test done");
    endtask
    task t_selfref;
        odtIn = 1'b1;
        cmd(`CMD_NOP, 1'b1, 3'h0, 13'h0, 2'h0, 2);
        chk("term on", {7'h0, termActive_ff}, 8'h01);
        cmd(`CMD_REFRESH, 1'b0, 3'h0, 13'h0, 2'h0, 2);
        chk("sr state", powerState_ff, 8'h80);
        chk("term off", {7'h0, termActive_ff}, 8'h00);
        ddr_ctrl_model_inst.hold_clock(1'b1);
        repeat (4) @(negedge clk);
        ddr_ctrl_model_inst.wake;
        repeat (10) @(negedge clk);
        chk("sr exit", {7'h0, powerState_ff[7]}, 8'h00);
        ddr_ctrl_model_inst.hold_clock(1'b0);
        repeat (500) @(posedge cmdClk);
        chk("write held", {7'h0, writeAllowed_ff}, 8'h00);
        repeat (30) @(posedge cmdClk);
        chk("write allowed", {7'h0, writeAllowed_ff}, 8'h01);
        $display("self-refresh test done");
    endtask
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        t_start;
        t_modes;
        t_write;
        t_power;
        t_selfref;
        print_verdict;
    end
    initial begin
        #1ms;
        failures++;
        print_verdict;
    end
endmodule // test_sdram_cmd_power_state_decode
`default_nettype wire
